// ===== hw/setc_pkg.sv
package setc_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CUT_W = 14;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] REG_CHAN_EN = 8'h00;
  localparam logic [7:0] REG_LPF_EN = 8'h04;
  localparam logic [7:0] REG_LPF_CUT_BASE = 8'h08;
  localparam logic [7:0] REG_LPF_APPLY = 8'h18;
  localparam logic [7:0] REG_TRIG_CFG = 8'h20;
  localparam logic [7:0] REG_TRIG_LEVEL = 8'h24;
  localparam logic [7:0] REG_AUTO_TMO = 8'h28;
  localparam logic [7:0] REG_TRIG_APPLY = 8'h2c;
  localparam logic [7:0] REG_TIMEBASE = 8'h30;
  localparam logic [7:0] REG_STATUS = 8'h34;
  localparam logic [7:0] REG_TRIG_ACTIVE = 8'h38;
  localparam logic [7:0] REG_TRIG_COUNT = 8'h3c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned CUT_VAL_LSB = 0;
  localparam int unsigned CUT_VAL_W = 12;
  localparam int unsigned CUT_UNIT_LSB = 12;
  localparam int unsigned TCFG_MODE_LSB = 0;
  localparam int unsigned TCFG_SRC_LSB = 2;
  localparam int unsigned TCFG_DIR_BIT = 4;
  localparam int unsigned APPLY_BIT = 0;
  localparam int unsigned REARM_BIT = 1;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [3:0] CHAN_EN_RST = 4'hf;
  localparam logic [3:0] LPF_EN_RST = 4'h0;
  localparam logic [13:0] LPF_CUT_RST = 14'h1001;
  localparam logic [4:0] TRIG_CFG_RST = 5'h01;
  localparam logic [31:0] TIMEBASE_RST = 32'h000003e8;
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned AUTO_TMO_US = 100;
  localparam logic [31:0] AUTO_TMO_RST = 32'(AUTO_TMO_US * CLK_MHZ);
  localparam logic [31:0] TIMEBASE_CONT_US = 32'h00030d40;

  typedef enum logic [1:0] {MODE_NONE, MODE_AUTO, MODE_REPEAT, MODE_SINGLE} setc_mode_t;
  typedef enum logic [1:0] {UNIT_HZ, UNIT_KHZ, UNIT_MHZ, UNIT_RSVD} setc_unit_t;

  // Cutoff to smoothing shift: largest k with fs/(6*2^k) >= fc
  function automatic logic [3:0] setc_cut_to_shift(input logic [13:0] cut, input longint fs_hz);
    longint freq;
    longint base;
    logic [3:0] k_sel;
    freq = longint'(cut[CUT_UNIT_LSB-1:CUT_VAL_LSB]);
    base = fs_hz / 6;
    k_sel = 4'h0;
    if (cut[13:12] == UNIT_KHZ)
    begin
      freq = freq * 1000;
    end
    else if (cut[13:12] != UNIT_HZ)
    begin
      freq = freq * 1000000;
    end
    for (int k = 0; k < 16; k++)
    begin
      if ((base >> k) >= freq)
      begin
        k_sel = 4'(k);
      end
    end
    return k_sel;
  endfunction

endpackage

// ===== hw/setc_low_pass_stage.sv
`timescale 1ns/1ps
`default_nettype none
module setc_low_pass_stage #(
  parameter int unsigned SAMPLE_W = 16
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_valid,
  input wire logic signed [SAMPLE_W-1:0] i_sample,
  input wire logic i_enable,
  input wire logic [3:0] i_shift,
  output logic o_valid,
  output logic signed [SAMPLE_W-1:0] o_sample
);

  // ****************************************
  // First order smoother
  // ****************************************
  localparam int unsigned FRAC_W = 16;
  localparam int unsigned ACC_W = SAMPLE_W + FRAC_W + 1;

  logic signed [ACC_W-1:0] acc;
  logic signed [ACC_W-1:0] x_ext;
  logic signed [ACC_W-1:0] next_acc;

  assign x_ext = ACC_W'(signed'(i_sample)) <<< FRAC_W;
  assign next_acc = acc + ((x_ext - acc) >>> i_shift);

  // Bypass keeps the accumulator on the input so enabling causes no step
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      acc <= '0;
    end
    else if (i_valid)
    begin
      acc <= i_enable ? next_acc : x_ext;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_valid <= 1'b0;
      o_sample <= '0;
    end
    else
    begin
      o_valid <= i_valid;
      if (i_valid)
      begin
        o_sample <= i_enable ? next_acc[FRAC_W +: SAMPLE_W] : i_sample;
      end
    end
  end

endmodule
`default_nettype wire

// ===== hw/setc_trigger_top.sv
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Function
// RL1: Four channels A to D, each opened or closed independently.
// RL2: Every channel has its own digital low-pass stage before measurement.
// RL3: Each low-pass stage has an enable and cutoff in Hz, kHz or MHz.
// RL4: Unconfirmed low-pass settings never take effect; previous settings stay.
// RL5: Edge mode fires when source crosses the threshold upward or downward.
// RL6: Time base of 200 ms/div or slower forces continuous capture; triggers still reported. While stopped, nothing is captured.
// RL7: Trigger mode selects exactly one of none, auto, repeat, single.
// RL8: None mode captures continuously and ignores trigger events.
// RL9: Auto mode waits for trigger but forces capture after a timeout.
// RL10: Repeat mode captures only on each trigger event.
// RL11: Single mode stops after one trigger until rearmed.
// RL12: Only the selected source channel can generate trigger events.
// RL13: Direction picks rising or falling crossing.
// RL14: Threshold is a programmable level compared with source samples.
// RL15: Auto timeout is a cycle count, restarted on arming and each trigger.
// RL16: Trigger settings apply atomically on confirmation.
module setc_trigger_top
  import setc_pkg::*;
#(
  parameter int unsigned SAMPLE_W = 16,
  parameter int unsigned RECORD_LEN = 256,
  parameter longint SAMPLE_RATE_HZ = 40000000
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [31:0] o_rd_data,
  input wire logic i_sample_valid,
  input wire logic [NUM_CH*SAMPLE_W-1:0] i_sample,
  output logic o_capture_valid,
  output logic [NUM_CH*SAMPLE_W-1:0] o_capture_data,
  output logic o_trig_event,
  output logic o_trig_forced,
  output logic o_stopped
);

  typedef enum logic [1:0] {ST_ARMED, ST_CAPTURE, ST_STOPPED} setc_state_t;
  localparam int unsigned REC_W = $clog2(RECORD_LEN + 1);

  // ****************************************
  // Register storage
  // ****************************************
  logic [NUM_CH-1:0] chan_en;
  logic [NUM_CH-1:0] lpf_en_stg;
  logic [NUM_CH-1:0] lpf_en_act;
  logic [CUT_W-1:0] lpf_cut_stg [NUM_CH];
  logic [3:0] lpf_shift_act [NUM_CH];
  logic [4:0] trig_cfg_stg;
  logic [SAMPLE_W-1:0] level_stg;
  logic [31:0] tmo_stg;
  setc_mode_t mode_act;
  logic [1:0] src_act;
  logic dir_act;
  logic signed [SAMPLE_W-1:0] level_act;
  logic [31:0] tmo_act;
  logic [31:0] timebase;
  logic [31:0] trig_count;
  logic wr_lpf_apply;
  logic wr_trig_apply;
  logic wr_rearm;

  assign wr_lpf_apply = i_wr_en && (i_addr == REG_LPF_APPLY) && i_wr_data[APPLY_BIT];
  assign wr_trig_apply = i_wr_en && (i_addr == REG_TRIG_APPLY) && i_wr_data[APPLY_BIT];
  assign wr_rearm = i_wr_en && (i_addr == REG_TRIG_APPLY) && i_wr_data[REARM_BIT];

  // RL1: per channel open
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      chan_en <= CHAN_EN_RST;
      timebase <= TIMEBASE_RST;
    end
    else if (i_wr_en)
    begin
      if (i_addr == REG_CHAN_EN)
      begin
        chan_en <= i_wr_data[NUM_CH-1:0];
      end
      else if (i_addr == REG_TIMEBASE)
      begin
        timebase <= i_wr_data;
      end
    end
  end

  // RL3: staged low-pass settings
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      lpf_en_stg <= LPF_EN_RST;
      for (int i = 0; i < NUM_CH; i++)
      begin
        lpf_cut_stg[i] <= LPF_CUT_RST;
      end
    end
    else if (i_wr_en)
    begin
      if (i_addr == REG_LPF_EN)
      begin
        lpf_en_stg <= i_wr_data[NUM_CH-1:0];
      end
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (i_addr == REG_LPF_CUT_BASE + 8'(4 * i))
        begin
          lpf_cut_stg[i] <= i_wr_data[CUT_W-1:0];
        end
      end
    end
  end

  // RL4: confirm copies staged values
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      lpf_en_act <= LPF_EN_RST;
      for (int i = 0; i < NUM_CH; i++)
      begin
        lpf_shift_act[i] <= setc_cut_to_shift(LPF_CUT_RST, SAMPLE_RATE_HZ);
      end
    end
    else if (wr_lpf_apply)
    begin
      lpf_en_act <= lpf_en_stg;
      for (int i = 0; i < NUM_CH; i++)
      begin
        lpf_shift_act[i] <= setc_cut_to_shift(lpf_cut_stg[i], SAMPLE_RATE_HZ);
      end
    end
  end

  // Staged trigger settings
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      trig_cfg_stg <= TRIG_CFG_RST;
      level_stg <= '0;
      tmo_stg <= AUTO_TMO_RST;
    end
    else if (i_wr_en)
    begin
      if (i_addr == REG_TRIG_CFG)
      begin
        trig_cfg_stg <= i_wr_data[4:0];
      end
      else if (i_addr == REG_TRIG_LEVEL)
      begin
        level_stg <= i_wr_data[SAMPLE_W-1:0];
      end
      else if (i_addr == REG_AUTO_TMO)
      begin
        tmo_stg <= i_wr_data;
      end
    end
  end

  // RL16: atomic trigger update
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      mode_act <= setc_mode_t'(TRIG_CFG_RST[TCFG_MODE_LSB +: 2]);
      src_act <= TRIG_CFG_RST[TCFG_SRC_LSB +: 2];
      dir_act <= TRIG_CFG_RST[TCFG_DIR_BIT];
      level_act <= '0;
      tmo_act <= AUTO_TMO_RST;
    end
    else if (wr_trig_apply)
    begin
      // RL7: one of four modes
      mode_act <= setc_mode_t'(trig_cfg_stg[TCFG_MODE_LSB +: 2]);
      src_act <= trig_cfg_stg[TCFG_SRC_LSB +: 2];
      dir_act <= trig_cfg_stg[TCFG_DIR_BIT];
      level_act <= signed'(level_stg);
      tmo_act <= tmo_stg;
    end
  end

  // ****************************************
  // Filters
  // ****************************************
  logic [NUM_CH-1:0] f_valid;
  logic signed [SAMPLE_W-1:0] f_sample [NUM_CH];

  // RL2: one stage per channel
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_lpf
    setc_low_pass_stage #(
      .SAMPLE_W(SAMPLE_W)
    ) u_stage (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_valid(i_sample_valid),
      .i_sample(i_sample[g*SAMPLE_W +: SAMPLE_W]),
      .i_enable(lpf_en_act[g]),
      .i_shift(lpf_shift_act[g]),
      .o_valid(f_valid[g]),
      .o_sample(f_sample[g])
    );
  end

  // ****************************************
  // Edge detection
  // ****************************************
  logic s_valid;
  logic src_above;
  logic prev_above;
  logic have_prev;
  logic trig_hit;

  assign s_valid = f_valid[0];
  // RL14: compare with threshold
  assign src_above = f_sample[src_act] > level_act;
  // RL5: crossing detection
  // RL13: direction select
  // RL12: only the selected source
  assign trig_hit = s_valid && have_prev && chan_en[src_act] &&
                    (dir_act ? (prev_above && !src_above) : (!prev_above && src_above));

  // History dropped on apply so a new level cannot fake a crossing
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      prev_above <= 1'b0;
      have_prev <= 1'b0;
    end
    else if (wr_trig_apply)
    begin
      have_prev <= 1'b0;
    end
    else if (s_valid)
    begin
      prev_above <= src_above;
      have_prev <= 1'b1;
    end
  end

  // ****************************************
  // Acquisition control
  // ****************************************
  setc_state_t state;
  setc_state_t next_state;
  logic [REC_W-1:0] rec_cnt;
  logic [31:0] tmo_cnt;
  logic continuous;
  logic free_run;
  logic forced;
  logic cap;
  logic rec_done;

  // RL6: slow time base is continuous
  assign continuous = timebase >= TIMEBASE_CONT_US;
  // RL8: none mode runs freely
  assign free_run = (mode_act == MODE_NONE) || continuous;
  // RL9: forced update on timeout
  assign forced = (state == ST_ARMED) && (mode_act == MODE_AUTO) && !free_run && !trig_hit &&
                  (tmo_cnt + 32'h1 >= tmo_act);
  // RL10: capture only after a trigger
  // Stopped record stays frozen even in continuous time base
  assign cap = s_valid && ((free_run && (state != ST_STOPPED)) || (state == ST_CAPTURE) ||
                           ((state == ST_ARMED) && trig_hit));
  assign rec_done = cap && (state == ST_CAPTURE) && (rec_cnt == REC_W'(RECORD_LEN - 1));

  always_comb
  begin
    next_state = state;
    if (wr_trig_apply || wr_rearm)
    begin
      next_state = ST_ARMED;
    end
    else
    begin
      case (state)
        ST_ARMED:
        begin
          if (!free_run && (trig_hit || forced))
          begin
            next_state = ST_CAPTURE;
          end
        end
        ST_CAPTURE:
        begin
          if (free_run)
          begin
            next_state = ST_ARMED;
          end
          else if (rec_done)
          begin
            // RL11: single stops here
            next_state = (mode_act == MODE_SINGLE) ? ST_STOPPED : ST_ARMED;
          end
        end
        default:
        begin
          next_state = ST_STOPPED;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state <= ST_ARMED;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rec_cnt <= '0;
    end
    else if (state != ST_CAPTURE)
    begin
      rec_cnt <= cap ? REC_W'(1) : '0;
    end
    else if (cap)
    begin
      rec_cnt <= rec_cnt + REC_W'(1);
    end
  end

  // RL15: timeout restarts on arm and trigger
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tmo_cnt <= '0;
    end
    else if ((state != ST_ARMED) || wr_trig_apply || wr_rearm || trig_hit || forced)
    begin
      tmo_cnt <= '0;
    end
    else
    begin
      tmo_cnt <= tmo_cnt + 32'h1;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_capture_valid <= 1'b0;
      o_capture_data <= '0;
      o_trig_event <= 1'b0;
      o_trig_forced <= 1'b0;
      trig_count <= '0;
    end
    else
    begin
      o_capture_valid <= cap;
      o_trig_event <= trig_hit;
      o_trig_forced <= forced;
      if (trig_hit)
      begin
        trig_count <= trig_count + 32'h1;
      end
      if (cap)
      begin
        // RL1: closed channels read zero
        for (int i = 0; i < NUM_CH; i++)
        begin
          o_capture_data[i*SAMPLE_W +: SAMPLE_W] <= chan_en[i] ? f_sample[i] : '0;
        end
      end
    end
  end

  assign o_stopped = (state == ST_STOPPED);

  // ****************************************
  // Read back
  // ****************************************
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0;
    if (i_addr == REG_CHAN_EN)
    begin
      rd_mux = 32'(chan_en);
    end
    else if (i_addr == REG_LPF_EN)
    begin
      rd_mux = {24'h0, lpf_en_stg, lpf_en_act};
    end
    else if (i_addr == REG_TRIG_CFG)
    begin
      rd_mux = 32'(trig_cfg_stg);
    end
    else if (i_addr == REG_TRIG_LEVEL)
    begin
      rd_mux = 32'(level_stg);
    end
    else if (i_addr == REG_AUTO_TMO)
    begin
      rd_mux = tmo_stg;
    end
    else if (i_addr == REG_TIMEBASE)
    begin
      rd_mux = timebase;
    end
    else if (i_addr == REG_STATUS)
    begin
      rd_mux = {27'h0, free_run, continuous, o_stopped, state};
    end
    else if (i_addr == REG_TRIG_ACTIVE)
    begin
      rd_mux = {11'h0, dir_act, src_act, mode_act, SAMPLE_W'(level_act)} >> 0;
    end
    else if (i_addr == REG_TRIG_COUNT)
    begin
      rd_mux = trig_count;
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (i_addr == REG_LPF_CUT_BASE + 8'(4 * i))
        begin
          rd_mux = {14'h0, lpf_shift_act[i], lpf_cut_stg[i]};
        end
      end
    end
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_rd_data <= '0;
    end
    else
    begin
      o_rd_data <= i_rd_en ? rd_mux : 32'h0;
    end
  end

endmodule
`default_nettype wire

// ===== sim/setc_trigger_properties.sv
`timescale 1ns/1ps
`default_nettype none
module setc_trigger_properties
  import setc_pkg::*;
#(
  parameter int unsigned SAMPLE_W = 16,
  parameter int unsigned RECORD_LEN = 256
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [31:0] o_rd_data,
  input wire logic i_sample_valid,
  input wire logic [NUM_CH*SAMPLE_W-1:0] i_sample,
  input wire logic o_capture_valid,
  input wire logic [NUM_CH*SAMPLE_W-1:0] o_capture_data,
  input wire logic o_trig_event,
  input wire logic o_trig_forced,
  input wire logic o_stopped
);
  // ****
  // Helpers
  // ****
  logic [3:0] chan_open;
  logic [NUM_CH*SAMPLE_W-1:0] lane_mask;
  logic rearm_wr;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      chan_open <= CHAN_EN_RST;
    else if (i_wr_en && i_addr == REG_CHAN_EN)
      chan_open <= i_wr_data[3:0];
  end
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
      lane_mask[i*SAMPLE_W +: SAMPLE_W] = {SAMPLE_W{!chan_open[i]}};
  end
  // Only apply or rearm writes may end a stop
  assign rearm_wr = i_wr_en && (i_addr == REG_TRIG_APPLY) && (i_wr_data[1:0] != 2'h0);
  sequence s_quiet_in;
    !i_sample_valid [*2];
  endsequence
  sequence s_stop_run;
    o_stopped [*3];
  endsequence
  // ****
  // Properties
  // ****
  chk_event_from_sample: assert property (o_trig_event |-> $past(i_sample_valid, 2))
    else $error("trigger event without a sample two cycles earlier");
  chk_quiet_no_capture: assert property (s_quiet_in |=> !o_capture_valid)
    else $error("capture without an input sample");
  chk_stopped_no_capture: assert property (s_stop_run |-> !o_capture_valid)
    else $error("capture while stopped");
  chk_stop_holds: assert property (o_stopped && !rearm_wr |=> o_stopped)
    else $error("stop released without rearm");
  chk_forced_pulse: assert property (o_trig_forced |=> !o_trig_forced)
    else $error("forced trigger longer than one cycle");
  chk_event_pulse: assert property (o_trig_event |=> !o_trig_event)
    else $error("edge event on two samples in a row");
  chk_capture_hold: assert property (!o_capture_valid |-> $stable(o_capture_data))
    else $error("capture data changed without capture");
  chk_closed_lane_zero: assert property (o_capture_valid && $stable(chan_open) && $past(chan_open, 2) == chan_open
    |-> (o_capture_data & lane_mask) == '0)
    else $error("closed channel lane not zero");
endmodule
bind setc_trigger_top setc_trigger_properties #(.SAMPLE_W(SAMPLE_W), .RECORD_LEN(RECORD_LEN)) i_props (
  .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
  .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_sample_valid(i_sample_valid), .i_sample(i_sample),
  .o_capture_valid(o_capture_valid), .o_capture_data(o_capture_data), .o_trig_event(o_trig_event),
  .o_trig_forced(o_trig_forced), .o_stopped(o_stopped));
`default_nettype wire

// ===== sim/setc_afe_model.sv
`timescale 1ns/1ps
`default_nettype none
module setc_afe_model
  import setc_pkg::*;
#(
  parameter int unsigned SAMPLE_W = 16
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_send,
  input wire logic i_slow,
  input wire logic [NUM_CH*SAMPLE_W-1:0] i_set,
  output logic o_valid,
  output logic [NUM_CH*SAMPLE_W-1:0] o_sample
);
  // ****
  // Digitiser output
  // ****
  logic pend;
  logic [NUM_CH*SAMPLE_W-1:0] held;
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_valid <= 1'b0;
      o_sample <= '0;
      pend <= 1'b0;
      held <= '0;
    end
    else
    begin
      // Lines toggle between sets so stale data is never mistaken for a sample
      o_valid <= pend || (i_send && !i_slow);
      o_sample <= pend ? held : (i_send && !i_slow) ? i_set : ~o_sample;
      pend <= i_send && i_slow;
      held <= i_set;
    end
  end
endmodule
`default_nettype wire

// ===== sim/tb_scope_edge_trigger_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_scope_edge_trigger_control
  import setc_pkg::*;
;
  typedef struct packed {
    logic [1:0] md;
    logic [1:0] sr;
    logic dr;
    logic [15:0] lv;
    logic [15:0] s0;
    logic [15:0] s1;
    logic [15:0] o0;
    logic [15:0] o1;
    logic [1:0] ev;
    logic [1:0] cp;
  } setc_row_t;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic send = 1'b0;
  logic slow = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic [63:0] set_val = 64'h0;
  logic [31:0] rd_data, v;
  logic smp_valid, cap_valid, trig_ev, trig_frc, stopped;
  logic [63:0] smp, cap_data, last_cap;
  int mismatches = 0;
  int tests_run = 0;
  int ev_cnt, cap_cnt, frc_cnt, n;
  setc_row_t rows [7] = '{
    '{2'd1, 2'd0, 1'b0, 16'h0010, 16'h0000, 16'h0020, 16'h0000, 16'h0000, 2'd1, 2'd1},
    '{2'd1, 2'd1, 1'b1, 16'h0010, 16'h0020, 16'h0000, 16'h0000, 16'h0020, 2'd1, 2'd1},
    '{2'd2, 2'd2, 1'b0, 16'hfff0, 16'hffe0, 16'h0000, 16'h0000, 16'h0000, 2'd1, 2'd1},
    '{2'd2, 2'd3, 1'b0, 16'h0010, 16'h0000, 16'h0008, 16'h0000, 16'h0020, 2'd0, 2'd0},
    '{2'd3, 2'd0, 1'b1, 16'h0010, 16'h0020, 16'h0020, 16'h0020, 16'h0000, 2'd0, 2'd0},
    '{2'd0, 2'd2, 1'b0, 16'h0010, 16'h0020, 16'h0000, 16'h0000, 16'h0020, 2'd0, 2'd1},
    '{2'd0, 2'd3, 1'b1, 16'h0010, 16'h0020, 16'h0000, 16'h0000, 16'h0000, 2'd1, 2'd1}};
  always #12.5 core_clk = ~core_clk;
  setc_trigger_top #(.RECORD_LEN(4)) i_dut (.i_core_clk(core_clk), .i_rst_b(rst_b), .i_addr(addr),
    .i_wr_data(wr_data), .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data), .i_sample_valid(smp_valid),
    .i_sample(smp), .o_capture_valid(cap_valid), .o_capture_data(cap_data), .o_trig_event(trig_ev),
    .o_trig_forced(trig_frc), .o_stopped(stopped));
  setc_afe_model i_afe (.i_core_clk(core_clk), .i_rst_b(rst_b), .i_send(send), .i_slow(slow),
    .i_set(set_val), .o_valid(smp_valid), .o_sample(smp));
  // ****
  // Monitor and tasks
  // ****
  always @(negedge core_clk)
  begin
    if (trig_ev === 1'b1)
      ev_cnt++;
    if (trig_frc === 1'b1)
      frc_cnt++;
    if (cap_valid === 1'b1)
    begin
      cap_cnt++;
      last_cap = cap_data;
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(negedge core_clk);
    d = rd_data;
  endtask
  task automatic put(input logic [63:0] s);
    @(posedge core_clk);
    send <= 1'b1;
    set_val <= s;
    @(posedge core_clk);
    send <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic cfg(input logic [1:0] md, input logic [1:0] sr, input logic dr, input logic [15:0] lv);
    wr(REG_TRIG_CFG, {27'h0, dr, sr, md});
    wr(REG_TRIG_LEVEL, {16'h0, lv});
    wr(REG_TRIG_APPLY, 32'h1);
  endtask
  task automatic clr();
    ev_cnt = 0;
    cap_cnt = 0;
    frc_cnt = 0;
  endtask
  function automatic logic [63:0] mk(input logic [1:0] sr, input logic [15:0] s, input logic [15:0] o);
    mk = {4{o}};
    mk[sr*16 +: 16] = s;
  endfunction
  task automatic final_report();
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #500000;
    mismatches++;
    final_report();
  end
  // ****
  // Sequence
  // ****
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    foreach (rows[i])
    begin
      slow <= i[0];
      cfg(rows[i].md, rows[i].sr, rows[i].dr, rows[i].lv);
      rd(REG_TRIG_ACTIVE, v);
      chk("active trigger", v, {11'h0, rows[i].dr, rows[i].sr, rows[i].md, rows[i].lv});
      put(mk(rows[i].sr, rows[i].s0, rows[i].o0));
      clr();
      put(mk(rows[i].sr, rows[i].s1, rows[i].o1));
      chk("events", 32'(ev_cnt), 32'(rows[i].ev));
      chk("captures", 32'(cap_cnt), 32'(rows[i].cp));
      $display("Row %0d done", i);
    end
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(REG_CHAN_EN, v);
    chk("channel open", v, 32'h0000000f);
    rd(REG_TRIG_ACTIVE, v);
    chk("active trigger", v, 32'h00010000);
    rd(8'h08, v);
    chk("cutoff A", v, 32'h00031001);
    wr(8'h40, 32'hffffffff);
    rd(8'h40, v);
    chk("unmapped", v, 32'h0);
    wr(8'h08, 32'h00002001);
    wr(REG_LPF_EN, 32'h1);
    rd(REG_LPF_EN, v);
    chk("filter enable", v, 32'h00000010);
    rd(8'h08, v);
    chk("cutoff A", v, 32'h00032001);
    wr(REG_LPF_APPLY, 32'h1);
    rd(REG_LPF_EN, v);
    chk("filter enable", v, 32'h00000011);
    rd(8'h08, v);
    chk("cutoff A", v, 32'h0000a001);
    wr(REG_CHAN_EN, 32'hd);
    cfg(2'd0, 2'd0, 1'b0, 16'h0);
    clr();
    put(64'h0000_0055_0123_0100);
    chk("captures", 32'(cap_cnt), 32'h1);
    chk("lanes A B", last_cap[31:0], 32'h00000040);
    chk("lanes C D", last_cap[63:32], 32'h00000055);
    $display("Filter test done");
    wr(REG_AUTO_TMO, 32'd40);
    wr(REG_TRIG_CFG, 32'h1);
    wr(REG_TRIG_LEVEL, 32'h7000);
    rd(REG_TRIG_ACTIVE, v);
    chk("active trigger", v, 32'h0);
    wr(REG_TRIG_APPLY, 32'h1);
    clr();
    n = 0;
    while (trig_frc !== 1'b1 && n < 200)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("forced delay", 32'(n >= 38 && n <= 43), 32'h1);
    repeat (5) put(64'h0);
    chk("captures", 32'(cap_cnt), 32'h4);
    chk("forced", 32'(frc_cnt), 32'h1);
    $display("Auto test done");
    // Raw samples keep the single and repeat levels exact
    wr(REG_LPF_EN, 32'h0);
    wr(REG_LPF_APPLY, 32'h1);
    cfg(2'd3, 2'd0, 1'b0, 16'h0010);
    clr();
    put(64'h0);
    put({4{16'h0020}});
    repeat (5) put(64'h0);
    chk("captures", 32'(cap_cnt), 32'h4);
    chk("stopped", {31'h0, stopped}, 32'h1);
    wr(REG_TRIG_APPLY, 32'h2);
    @(negedge core_clk);
    chk("stopped", {31'h0, stopped}, 32'h0);
    $display("Single test done");
    cfg(2'd2, 2'd0, 1'b0, 16'h0010);
    clr();
    put(64'h0);
    put(64'h0);
    chk("captures", 32'(cap_cnt), 32'h0);
    wr(REG_TIMEBASE, 32'h00030d3f);
    rd(REG_STATUS, v);
    chk("continuous", {31'h0, v[3]}, 32'h0);
    wr(REG_TIMEBASE, TIMEBASE_CONT_US);
    rd(REG_STATUS, v);
    chk("continuous", {31'h0, v[3]}, 32'h1);
    clr();
    put(64'h0);
    put({4{16'h0020}});
    chk("captures", 32'(cap_cnt), 32'h2);
    chk("events", 32'(ev_cnt), 32'h1);
    $display("Repeat test done");
    final_report();
  end
endmodule
`default_nettype wire
